// ===== logic/tmo_pkg.sv
package tmo_pkg;

  typedef enum logic [2:0] {
    TMO_IDLE = 3'b001,
    TMO_RUN = 3'b010,
    TMO_DONE = 3'b100
  } tmo_state_e;

  typedef logic [2:0] tmo_rate_t;

endpackage

// ===== logic/tmo_prescaler.sv
`include "tmo_regs.svh"

module tmo_prescaler
  import tmo_pkg::*;
#(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic clear,
  input wire tmo_rate_t rate_sel,
  input wire logic ifc_tick,
  // Output
  output logic pre_tick
);

  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic [DIV_W-1:0] mask;

  // ----------------------------------------
  // Divide interface tick by 2^(rate_sel+1)
  // ----------------------------------------
  always_comb begin
    mask = DIV_W'((2 << rate_sel) - 1);
    div_d = div_q;
    pre_tick = 1'b0;
    if (clear) begin
      div_d = '0;
    end else if (ifc_tick) begin
      div_d = DIV_W'(div_q + 1'b1);
      pre_tick = ((div_q & mask) == mask);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

endmodule

// ===== logic/tmo_regs.svh
`ifndef TMO_REGS_SVH
`define TMO_REGS_SVH

// Register offsets
`define TMO_CFG_OFS 4'h0
`define TMO_PRESET_OFS 4'h4
`define TMO_COUNT_OFS 4'h8
`define TMO_STAT_OFS 4'hC

// Configuration field positions
`define TMO_CFG_RUN_BIT 0
`define TMO_CFG_RELOAD_BIT 1
`define TMO_CFG_SRC_BIT 2
`define TMO_CFG_RATE_LSB 3
`define TMO_CFG_RATE_MSB 5

// Status field positions
`define TMO_STAT_RUNNING_BIT 0
`define TMO_STAT_EXPIRED_BIT 1

// Reset values
`define TMO_CFG_RST 6'h00
`define TMO_PRESET_RST 20'h00000
`define TMO_COUNT_RST 20'h00000

// Clock rates in kHz for the interface tick
`define TMO_IFC_KHZ 13560
`define TMO_SYS_KHZ 40000

`endif

// ===== logic/tmo_timer.sv
// What this block does
// - Source select zero counts on interface clock.
// - Source select one counts on prescaled tick.
// - Reload off: halt at zero on expiry.
// - Reload on: load preset, keep counting.
// - Enable bit zero, reset clear, gates timer.
//
// Our own choices: the register addresses and the address-and-strobe port.
`include "tmo_regs.svh"

module tmo_timer
  import tmo_pkg::*;
#(
  parameter int CNT_W = 20,
  parameter int ACC_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Timer state
  output logic timer_one_expired,
  output logic timer_one_running,
  output logic [CNT_W-1:0] timer_one_count
);

  // ----------------------------------------
  // Interface clock tick constants
  // ----------------------------------------
  localparam logic [ACC_W-1:0] ACC_STEP =
    ACC_W'(`TMO_IFC_KHZ);
  localparam logic [ACC_W-1:0] ACC_MOD =
    ACC_W'(`TMO_SYS_KHZ);
  localparam logic [5:0] CFG_RST = `TMO_CFG_RST;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic timer_one_run_enable_q;
  logic timer_one_run_enable_d;
  logic timer_one_autoreload_on_q;
  logic timer_one_autoreload_on_d;
  logic timer_one_clock_source_select_q;
  logic timer_one_clock_source_select_d;
  tmo_rate_t timer_one_tick_rate_select_q;
  tmo_rate_t timer_one_tick_rate_select_d;
  logic [CNT_W-1:0] preset_q;
  logic [CNT_W-1:0] preset_d;

  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_d;
  logic [ACC_W:0] acc_sum;
  logic ifc_tick;
  logic pre_tick;
  logic count_tick;
  logic pre_clear;

  tmo_state_e state_q;
  tmo_state_e state_d;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic expired_q;
  logic expired_d;
  logic sticky_q;
  logic sticky_d;
  logic expiry;
  logic start;

  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic wr_cfg;
  logic wr_preset;
  logic wr_stat;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  always_comb begin
    wr_cfg = reg_wr && (reg_addr == `TMO_CFG_OFS);
    wr_preset = reg_wr && (reg_addr == `TMO_PRESET_OFS);
    wr_stat = reg_wr && (reg_addr == `TMO_STAT_OFS);
  end

  // ----------------------------------------
  // Configuration and preset registers
  // ----------------------------------------
  always_comb begin
    timer_one_run_enable_d = timer_one_run_enable_q;
    timer_one_autoreload_on_d = timer_one_autoreload_on_q;
    timer_one_clock_source_select_d =
      timer_one_clock_source_select_q;
    timer_one_tick_rate_select_d = timer_one_tick_rate_select_q;
    preset_d = preset_q;
    if (wr_cfg) begin
      timer_one_run_enable_d =
        reg_wdata[`TMO_CFG_RUN_BIT];
      timer_one_autoreload_on_d = reg_wdata[`TMO_CFG_RELOAD_BIT];
      timer_one_clock_source_select_d =
        reg_wdata[`TMO_CFG_SRC_BIT];
      timer_one_tick_rate_select_d =
        reg_wdata[`TMO_CFG_RATE_MSB:`TMO_CFG_RATE_LSB];
    end
    if (wr_preset) begin
      preset_d = reg_wdata[CNT_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_one_run_enable_q <= CFG_RST[`TMO_CFG_RUN_BIT];
      timer_one_autoreload_on_q <= CFG_RST[`TMO_CFG_RELOAD_BIT];
      timer_one_clock_source_select_q <= CFG_RST[`TMO_CFG_SRC_BIT];
      timer_one_tick_rate_select_q <=
        CFG_RST[`TMO_CFG_RATE_MSB:`TMO_CFG_RATE_LSB];
      preset_q <= `TMO_PRESET_RST;
    end else begin
      timer_one_run_enable_q <= timer_one_run_enable_d;
      timer_one_autoreload_on_q <= timer_one_autoreload_on_d;
      timer_one_clock_source_select_q <=
        timer_one_clock_source_select_d;
      timer_one_tick_rate_select_q <= timer_one_tick_rate_select_d;
      preset_q <= preset_d;
    end
  end

  // ----------------------------------------
  // Interface clock tick from system clock
  // ----------------------------------------
  always_comb begin
    acc_sum = {1'b0, acc_q} + {1'b0, ACC_STEP};
    ifc_tick = (acc_sum >= {1'b0, ACC_MOD});
    if (ifc_tick) begin
      acc_d = ACC_W'(acc_sum - {1'b0, ACC_MOD});
    end else begin
      acc_d = acc_sum[ACC_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_d;
    end
  end

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  assign pre_clear = start;

  tmo_prescaler #(
    .DIV_W(8)
  ) u_prescaler (
    .clk(clk),
    .rst(rst),
    .clear(pre_clear),
    .rate_sel(timer_one_tick_rate_select_q),
    .ifc_tick(ifc_tick),
    .pre_tick(pre_tick)
  );

  // ----------------------------------------
  // Tick selection
  // ----------------------------------------
  always_comb begin
    if (timer_one_clock_source_select_q) begin
      count_tick = pre_tick;
    end else begin
      count_tick = ifc_tick;
    end
  end

  // ----------------------------------------
  // Counter state machine
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    count_d = count_q;
    expiry = 1'b0;
    start = 1'b0;
    case (state_q)
      TMO_IDLE: begin
        if (timer_one_run_enable_q) begin
          start = 1'b1;
          count_d = preset_q;
          state_d = TMO_RUN;
        end
      end
      TMO_RUN: begin
        if (!timer_one_run_enable_q) begin
          state_d = TMO_IDLE;
        end else if (count_q == '0) begin
          expiry = 1'b1;
          if (timer_one_autoreload_on_q) begin
            count_d = preset_q;
          end else begin
            state_d = TMO_DONE;
          end
        end else if (count_tick) begin
          count_d = CNT_W'(count_q - 1'b1);
          if (count_q == CNT_W'(1)) begin
            expiry = 1'b1;
            if (timer_one_autoreload_on_q) begin
              count_d = preset_q;
            end else begin
              state_d = TMO_DONE;
            end
          end
        end
      end
      TMO_DONE: begin
        count_d = '0;
        if (!timer_one_run_enable_q) begin
          state_d = TMO_IDLE;
        end
      end
      default: begin
        state_d = TMO_IDLE;
        count_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= TMO_IDLE;
      count_q <= `TMO_COUNT_RST;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  // ----------------------------------------
  // Expiry pulse and sticky status
  // ----------------------------------------
  always_comb begin
    expired_d = expiry;
    sticky_d = sticky_q;
    if (wr_stat && reg_wdata[`TMO_STAT_EXPIRED_BIT]) begin
      sticky_d = 1'b0;
    end
    if (expiry) begin
      sticky_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      expired_q <= 1'b0;
      sticky_q <= 1'b0;
    end else begin
      expired_q <= expired_d;
      sticky_q <= sticky_d;
    end
  end

  // ----------------------------------------
  // Read back
  // ----------------------------------------
  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      case (reg_addr)
        `TMO_CFG_OFS: begin
          rdata_d[`TMO_CFG_RUN_BIT] = timer_one_run_enable_q;
          rdata_d[`TMO_CFG_RELOAD_BIT] = timer_one_autoreload_on_q;
          rdata_d[`TMO_CFG_SRC_BIT] =
            timer_one_clock_source_select_q;
          rdata_d[`TMO_CFG_RATE_MSB:`TMO_CFG_RATE_LSB] =
            timer_one_tick_rate_select_q;
        end
        `TMO_PRESET_OFS: begin
          rdata_d[CNT_W-1:0] = preset_q;
        end
        `TMO_COUNT_OFS: begin
          rdata_d[CNT_W-1:0] = count_q;
        end
        `TMO_STAT_OFS: begin
          rdata_d[`TMO_STAT_RUNNING_BIT] = (state_q == TMO_RUN);
          rdata_d[`TMO_STAT_EXPIRED_BIT] = sticky_q;
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata = rdata_q;
  assign timer_one_expired = expired_q;
  assign timer_one_running = (state_q == TMO_RUN);
  assign timer_one_count = count_q;

endmodule

// ===== test/tb_tmo_timer.sv
module tb_tmo_timer;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [5:0] cfg;
    logic [19:0] pre;
    int wt;
    logic [19:0] lo;
    logic [19:0] hi;
    logic [1:0] st;
  } tmo_row_s;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, d, c1;
  logic expd, run;
  logic [19:0] cnt;
  int fail_count = 0;
  int cmp_count = 0;
  logic [3:0] addrs [5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
  tmo_row_s rows [6] = '{
    '{6'h01, 20'h00005, 20, 20'h00000, 20'h00000, 2'h2},
    '{6'h03, 20'h00004, 60, 20'h00001, 20'h00004, 2'h3},
    '{6'h05, 20'h00003, 60, 20'h00000, 20'h00000, 2'h2},
    '{6'h3D, 20'h00002, 60, 20'h00002, 20'h00002, 2'h1},
    '{6'h01, 20'h00000, 10, 20'h00000, 20'h00000, 2'h2},
    '{6'h15, 20'h00003, 60, 20'h00001, 20'h00001, 2'h1}};

  always #12.5 clk = ~clk;

  tmo_timer dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .timer_one_expired(expd),
    .timer_one_running(run), .timer_one_count(cnt));

  task automatic check(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  task automatic summarize();
    $display("Compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    summarize();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr(4'h0, 32'h00000000);
      wr(4'hC, 32'h00000002);
      wr(4'h4, {12'h000, rows[i].pre});
      wr(4'h0, {26'h0000000, rows[i].cfg});
      repeat (rows[i].wt) @(posedge clk);
      rd(4'h8);
      check("count", d >= rows[i].lo && d <= rows[i].hi, 1'b1);
      rd(4'hC);
      check("status", d, {30'h00000000, rows[i].st});
      $display("Row %0d done", i);
    end
    // ------
    // Stop holds count, restart reloads
    // ------
    wr(4'h0, 32'h00000000);
    wr(4'h4, 32'h000000C8);
    wr(4'h0, 32'h00000001);
    repeat (20) @(posedge clk);
    wr(4'h0, 32'h00000000);
    rd(4'h8);
    c1 = d;
    repeat (10) @(posedge clk);
    rd(4'h8);
    check("held count", d, c1);
    check("count moved", c1 < 32'h000000C8, 1'b1);
    wr(4'h0, 32'h00000001);
    rd(4'h8);
    check("reloaded", d >= 32'h000000C6, 1'b1);
    $display("Hold test done");
    // ------
    // Reset in mid-run
    // ------
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("running", run, 1'b0);
    check("reset count", cnt, 20'h00000);
    check("reset pulse", expd, 1'b0);
    foreach (addrs[i]) begin
      rd(addrs[i]);
      check("reset read", d, 32'h00000000);
    end
    wr(4'h8, 32'h00000123);
    rd(4'h8);
    check("count read only", d, 32'h00000000);
    $display("Reset test done");
    // ------
    // Expiry pulse, halt, set beating clear
    // ------
    wr(4'h0, 32'h00000001);
    @(posedge clk);
    @(negedge clk);
    check("started", run, 1'b1);
    check("no early pulse", expd, 1'b0);
    @(negedge clk);
    check("expiry pulse", expd, 1'b1);
    check("halt count", cnt, 20'h00000);
    check("halted", run, 1'b0);
    @(negedge clk);
    check("pulse end", expd, 1'b0);
    wr(4'h0, 32'h00000000);
    wr(4'h0, 32'h00000003);
    repeat (3) @(posedge clk);
    wr(4'hC, 32'h00000002);
    rd(4'hC);
    check("set wins", d, 32'h00000003);
    check("reload pulse", expd, 1'b1);
    check("reload count", cnt, 20'h00000);
    $display("Expiry test done");
    summarize();
  end
endmodule

// ===== test/tmo_timer_properties.sv
module tmo_timer_properties
  import tmo_pkg::*;
#(
  parameter int CNT_W = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Timer state
  input wire logic timer_one_expired,
  input wire logic timer_one_running,
  input wire logic [CNT_W-1:0] timer_one_count
);
  // ------
  // Shadow of config and preset
  // ------
  logic [5:0] cfg_q, cfg_d;
  logic [CNT_W-1:0] pre_q, pre_d;

  always_comb begin
    cfg_d = cfg_q;
    pre_d = pre_q;
    if (reg_wr && reg_addr == 4'h0) cfg_d = reg_wdata[5:0];
    if (reg_wr && reg_addr == 4'h4) pre_d = reg_wdata[CNT_W-1:0];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q <= 6'h00;
      pre_q <= '0;
    end else begin
      cfg_q <= cfg_d;
      pre_q <= pre_d;
    end
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_go;
    reg_wr && reg_addr == 4'h0 && reg_wdata[0] && !cfg_q[0];
  endsequence

  sequence s_out(bit r);
    $past(timer_one_running) && $past(cfg_q[0]) && $past(cfg_q[1]) == r
      && $past(timer_one_count) == 1 && timer_one_count != 1;
  endsequence

  start_run_a: assert property (s_go |-> ##2
    (timer_one_running && timer_one_count == pre_q))
    else $error("timer did not start with preset");
  idle_off_a: assert property (!cfg_q[0] |=> !timer_one_running)
    else $error("timer runs while disabled");
  step_one_a: assert property (timer_one_running && timer_one_count > 1
    |=> timer_one_count == $past(timer_one_count)
      || timer_one_count == $past(timer_one_count) - 1'b1)
    else $error("count step not one");
  pre_rate_a: assert property (timer_one_running && cfg_q[2]
    && $past(cfg_q[2], 3) && $changed(timer_one_count)
    |=> $stable(timer_one_count))
    else $error("prescaled tick too fast");
  halt_zero_a: assert property (s_out(1'b0) |->
    timer_one_count == 0 && !timer_one_running)
    else $error("timer did not halt at zero");
  reload_pre_a: assert property (s_out(1'b1) |->
    timer_one_running && timer_one_count == $past(pre_q))
    else $error("timer did not reload preset");
  expiry_flag_a: assert property (s_out(1'b0) or s_out(1'b1)
    |-> ##[0:1] timer_one_expired)
    else $error("expiry flag missing");
  reset_run_a: assert property ($fell(rst) |-> !timer_one_running)
    else $error("running after reset");
endmodule

bind tmo_timer tmo_timer_properties #(.CNT_W(CNT_W)) u_props (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .timer_one_expired(timer_one_expired),
  .timer_one_running(timer_one_running),
  .timer_one_count(timer_one_count));
